// ### resp_store.sv
// response body store, capped at the expected length
`timescale 1ns/100ps
`default_nettype none
module resp_store (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       clr_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wr_byte_i,
    input  wire logic [8:0] cap_i,
    input  wire logic [8:0] rd_idx_i,
    output logic      [7:0] rd_byte_o,
    output logic      [8:0] count_o
);
    import t0_apdu_pkg::*;

    logic [7:0] mem_r [0:255];
    logic [8:0] count_r;

    // bytes past the cap are dropped so a chatty card cannot wrap the store
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || clr_i) begin
            count_r <= CNT_ZERO;
        end else if (wr_i && count_r < cap_i) begin
            count_r <= count_r + 9'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (wr_i && count_r < cap_i) begin
            mem_r[count_r[7:0]] <= wr_byte_i;
        end
    end

    assign rd_byte_o = mem_r[rd_idx_i[7:0]];
    assign count_o   = count_r;

endmodule : resp_store
`default_nettype wire

// ### sw_classify.sv
// sorts a card status pair into procedure pairs and status classes
`timescale 1ns/100ps
`default_nettype none
module sw_classify (
    input  wire t0_apdu_pkg::rsp_trailer_t sw_i,
    output logic                           is_more_o,
    output logic                           is_resend_o,
    output logic                           is_warn_app_o
);
    import t0_apdu_pkg::*;

    logic is_warn;
    logic is_app;

    assign is_more_o   = (sw_i.sw1 == SW1_MORE);
    assign is_resend_o = (sw_i.sw1 == SW1_RESEND);
    assign is_warn     = (sw_i.sw1 == SW1_WARN_A) || (sw_i.sw1 == SW1_WARN_B);
    assign is_app      = (sw_i.sw1[7:4] == SW1_APP_NIB) && (sw_i != SW_NORMAL);
    assign is_warn_app_o = is_warn || is_app;

endmodule : sw_classify
`default_nettype wire

// ### t0_apdu_pkg.sv
// shared types and constants of the t0 apdu transport engine
`default_nettype none
package t0_apdu_pkg;

    localparam logic [7:0] SW1_MORE       = 8'h61;
    localparam logic [7:0] SW1_RESEND     = 8'h6c;
    localparam logic [7:0] SW1_WARN_A     = 8'h62;
    localparam logic [7:0] SW1_WARN_B     = 8'h63;
    localparam logic [3:0] SW1_APP_NIB    = 4'h9;
    localparam logic [15:0] SW_NORMAL     = 16'h9000;

    localparam logic [7:0] GR_CLA         = 8'h00;
    localparam logic [7:0] GR_INS         = 8'hc0;
    localparam logic [7:0] GR_PARAM       = 8'h00;
    localparam logic [7:0] P3_ZERO        = 8'h00;

    localparam logic [2:0] HDR_LEN        = 3'h5;
    localparam logic [8:0] RSP_MAX        = 9'h100;
    localparam logic [8:0] CNT_ZERO       = 9'h000;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    typedef enum logic [1:0] {
        CASE_1,
        CASE_2,
        CASE_3,
        CASE_4
    } apdu_case_t;

    typedef enum logic [1:0] {
        EV_PROC,
        EV_DATA,
        EV_STATUS
    } card_ev_kind_t;

    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } t0_hdr_t;

    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        apdu_case_t cmd_case;
        logic [7:0] lc;
        logic [7:0] le;
        logic       fixed_le;
    } apdu_cmd_t;

    typedef struct packed {
        card_ev_kind_t kind;
        logic [7:0]    b1;
        logic [7:0]    b2;
    } card_ev_t;

    typedef struct packed {
        logic [7:0] sw1;
        logic [7:0] sw2;
    } rsp_trailer_t;

endpackage : t0_apdu_pkg
`default_nettype wire

// ### t0_apdu_transport.sv
// t0 transport engine: maps c-apdus to card headers and builds r-apdus
// Operation
// [R1] 61xx and 6Cxx pairs are consumed internally, never delivered as status.
// [R2] 9000 is normal; any other status ends the command and delivers.
// [R3] case 4 right after data: warning or application status continues.
// [R4] card status always concerns the latest command, GET RESPONSE included.
// [R5] case 1 header is the four bytes plus P3 of 00.
// [R6] card tells case 1 from case 2 on P3 zero, then returns status.
// [R7] final or terminating status goes unmodified into the trailer.
// [R8] case 2 header carries Le in P3.
// [R9] selection record reads and payment case 2 commands use Le 00.
// [R10] case 2 card returns data then status, steered by procedure pairs.
// [R11] returned data fills the body; no data leaves the body empty.
// [R12] case 3 and 4 headers carry Lc in P3.
// [R13] after a case 3/4 header, procedure sends data, status ends.
// [R14] case 3 card returns status after all data is processed.
// [R15] selection selects and payment case 4 commands use Le 00.
// [R16] case 4 card answers 61xx normally, else status only.
// [R17] on 61xx, GET RESPONSE is sent with P3 equal to xx.
// [R18] case 4 post-data warning or app status sends GET RESPONSE, Le 00.
// [R19] any other case 4 post-data status ends without GET RESPONSE.
// [R20] GET RESPONSE is then handled like a case 2 exchange.
// [R21] case 4 trailer holds the first status seen in the whole sequence.
// [R22] on 6Cxx the previous header is resent at once with P3 set to xx.
// [R23] GET RESPONSE header is 00 C0 00 00 with P3 as length.
// [R24] Le of zero means up to 256 response bytes.
// [R25] all response bytes are buffered and delivered with the trailer; bytes past the effective Le (256 for zero) are dropped.
`timescale 1ns/100ps
`default_nettype none
module t0_apdu_transport (
    input  wire logic                         ref_clk_i,
    input  wire logic                         nrst_i,
    // terminal application layer: command in
    input  wire logic                         cmd_valid_i,
    input  wire t0_apdu_pkg::apdu_cmd_t       cmd_i,
    output logic                              cmd_ready_o,
    input  wire logic                         dat_valid_i,
    input  wire logic [7:0]                   dat_byte_i,
    output logic                              dat_ready_o,
    // terminal application layer: response out
    output logic                              rsp_valid_o,
    output logic [7:0]                        rsp_byte_o,
    input  wire logic                         rsp_ready_i,
    output logic                              done_o,
    output t0_apdu_pkg::rsp_trailer_t         trailer_o,
    output logic [8:0]                        body_len_o,
    // chip card side
    output logic                              tx_valid_o,
    output logic [7:0]                        tx_byte_o,
    input  wire logic                         tx_ready_i,
    input  wire logic                         ev_valid_i,
    input  wire t0_apdu_pkg::card_ev_t        ev_i
);
    import t0_apdu_pkg::*;

    default clocking chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_WAIT,
        ST_DATA,
        ST_DLV,
        ST_FIN
    } state_t;

    state_t       state_r;
    t0_hdr_t      hdr_r;
    apdu_case_t   case_r;
    logic [7:0]   lc_r;
    logic [8:0]   cap_r;
    logic [2:0]   hdr_idx_r;
    logic [7:0]   sent_r;
    logic         post_data_r;
    logic         gr_r;
    logic         have_sw_r;
    rsp_trailer_t first_sw_r;
    logic [8:0]   rd_idx_r;
    logic         tx_valid_r;
    logic [7:0]   tx_byte_r;
    logic         dat_ready_r;
    logic         cmd_ready_r;
    logic         rsp_valid_r;
    logic [7:0]   rsp_byte_r;
    logic         done_r;
    rsp_trailer_t trailer_r;
    logic [8:0]   body_len_r;

    rsp_trailer_t ev_sw;
    logic         is_more;
    logic         is_resend;
    logic         is_warn_app;
    logic         cmd_take;
    logic         dat_take;
    logic         hdr_load;
    logic         st_ev;
    logic         data_ev;
    logic         proc_ev;
    logic         do_more;
    logic         do_resend;
    logic         do_gr00;
    logic         do_end;
    logic [7:0]   le_eff;
    logic [7:0]   hdr_byte;
    logic [7:0]   rd_byte;
    logic [8:0]   count;

    assign ev_sw     = '{sw1: ev_i.b1, sw2: ev_i.b2};
    assign cmd_take  = cmd_valid_i && cmd_ready_r;
    assign dat_take  = dat_valid_i && dat_ready_r;
    assign hdr_load  = (state_r == ST_HDR) && !tx_valid_r
                       && (hdr_idx_r != HDR_LEN);
    assign st_ev     = (state_r == ST_WAIT) && ev_valid_i
                       && (ev_i.kind == EV_STATUS);
    assign data_ev   = (state_r == ST_WAIT) && ev_valid_i
                       && (ev_i.kind == EV_DATA);
    assign proc_ev   = (state_r == ST_WAIT) && ev_valid_i
                       && (ev_i.kind == EV_PROC);

    // procedure pairs keep the command open; only other statuses end it
    assign do_resend = st_ev && is_resend;                                // R1
    assign do_more   = st_ev && is_more;                                  // R1
    assign do_gr00   = st_ev && !is_more && !is_resend && post_data_r
                       && is_warn_app && case_r == CASE_4;                // R3
    assign do_end    = st_ev && !is_more && !is_resend && !do_gr00;   // R2 R19

    // flow-fixed commands force Le to zero
    assign le_eff = cmd_i.fixed_le ? P3_ZERO : cmd_i.le;                  // R9

    always_comb begin
        unique case (hdr_idx_r)
            3'h0:    hdr_byte = hdr_r.cla;
            3'h1:    hdr_byte = hdr_r.ins;
            3'h2:    hdr_byte = hdr_r.p1;
            3'h3:    hdr_byte = hdr_r.p2;
            default: hdr_byte = hdr_r.p3;
        endcase
    end

    sw_classify u_classify (
        .sw_i          (ev_sw),
        .is_more_o     (is_more),
        .is_resend_o   (is_resend),
        .is_warn_app_o (is_warn_app)
    );

    resp_store u_store (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .clr_i     (cmd_take),
        .wr_i      (data_ev),                                             // R11
        .wr_byte_i (ev_i.b1),
        .cap_i     (cap_r),
        .rd_idx_i  (rd_idx_r),
        .rd_byte_o (rd_byte),
        .count_o   (count)
    );

    // command phase sequencing
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (cmd_take) state_r <= ST_HDR;
                ST_HDR: begin
                    if (!tx_valid_r && hdr_idx_r == HDR_LEN) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (do_resend || do_more || do_gr00) begin
                        state_r <= ST_HDR;                                // R22
                    end else if (do_end) begin
                        state_r <= ST_DLV;
                    end else if (proc_ev && !post_data_r && !gr_r
                                 && (case_r inside {CASE_3, CASE_4})) begin
                        state_r <= ST_DATA;                               // R13
                    end
                end
                ST_DATA: begin
                    if (!tx_valid_r && sent_r == lc_r) state_r <= ST_WAIT;
                end
                ST_DLV: begin
                    if ((!rsp_valid_r || rsp_ready_i)
                        && rd_idx_r == count) begin
                        state_r <= ST_FIN;
                    end
                end
                ST_FIN: state_r <= ST_IDLE;
            endcase
        end
    end

    // header image: built from the command, then patched by the card
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hdr_r   <= '0;
            case_r  <= CASE_1;
            lc_r    <= BYTE_ZERO;
            cap_r   <= CNT_ZERO;
        end else if (cmd_take) begin
            hdr_r.cla <= cmd_i.cla;
            hdr_r.ins <= cmd_i.ins;
            hdr_r.p1  <= cmd_i.p1;
            hdr_r.p2  <= cmd_i.p2;
            case_r    <= cmd_i.cmd_case;
            lc_r      <= cmd_i.lc;
            unique case (cmd_i.cmd_case)
                CASE_1: hdr_r.p3 <= P3_ZERO;                              // R5
                CASE_2: hdr_r.p3 <= le_eff;                               // R8
                CASE_3: hdr_r.p3 <= cmd_i.lc;                             // R12
                CASE_4: hdr_r.p3 <= cmd_i.lc;                             // R12
            endcase
            // R15: case 4 flow commands also take Le of zero here
            cap_r <= (le_eff == P3_ZERO) ? RSP_MAX : {1'b0, le_eff};      // R24
        end else if (do_resend) begin
            hdr_r.p3 <= ev_i.b2;                                          // R22
        end else if (do_more || do_gr00) begin
            hdr_r.cla <= GR_CLA;                                          // R23
            hdr_r.ins <= GR_INS;
            hdr_r.p1  <= GR_PARAM;
            hdr_r.p2  <= GR_PARAM;
            hdr_r.p3  <= do_more ? ev_i.b2 : P3_ZERO;                     // R17 R18
        end
    end

    // exchange progress flags
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cmd_take) begin
            post_data_r <= 1'b0;
            gr_r        <= 1'b0;
        end else begin
            if (state_r == ST_DATA && !tx_valid_r && sent_r == lc_r) begin
                post_data_r <= 1'b1;
            end else if (st_ev) begin
                // the chance to continue exists only on the first reply
                post_data_r <= 1'b0;                                      // R3
            end
            if (do_more || do_gr00) begin
                gr_r <= 1'b1;                                             // R20
            end
        end
    end

    // first real status of a case 4 sequence is kept for the trailer
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cmd_take) begin
            have_sw_r  <= 1'b0;
            first_sw_r <= '0;
        end else if (st_ev && !is_more && !is_resend && !have_sw_r
                     && case_r == CASE_4) begin
            have_sw_r  <= 1'b1;                                           // R21
            first_sw_r <= ev_sw;
        end
    end

    // header byte index, rewound for each resend or GET RESPONSE
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cmd_take || do_resend || do_more || do_gr00) begin
            hdr_idx_r <= 3'h0;
        end else if (hdr_load) begin
            hdr_idx_r <= hdr_idx_r + 3'h1;
        end
    end

    // command data count toward the card
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || cmd_take) begin
            sent_r <= BYTE_ZERO;
        end else if (dat_take) begin
            sent_r <= sent_r + 8'h01;
        end
    end

    // one byte in flight keeps the ready term a plain flop
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            dat_ready_r <= 1'b0;
        end else begin
            dat_ready_r <= (state_r == ST_DATA) && !tx_valid_r && !dat_take
                           && (sent_r != lc_r);                           // R13
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tx_valid_r <= 1'b0;
            tx_byte_r  <= BYTE_ZERO;
        end else if (hdr_load) begin
            tx_valid_r <= 1'b1;
            tx_byte_r  <= hdr_byte;
        end else if (dat_take) begin
            tx_valid_r <= 1'b1;
            tx_byte_r  <= dat_byte_i;
        end else if (tx_ready_i) begin
            tx_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cmd_ready_r <= 1'b0;
        end else begin
            cmd_ready_r <= (state_r == ST_IDLE) && !cmd_take;
        end
    end

    // delivery of the buffered body ahead of the trailer
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rsp_valid_r <= 1'b0;
            rsp_byte_r  <= BYTE_ZERO;
            rd_idx_r    <= CNT_ZERO;
        end else if (cmd_take) begin
            rd_idx_r <= CNT_ZERO;
        end else if (state_r == ST_DLV && (!rsp_valid_r || rsp_ready_i)) begin
            if (rd_idx_r != count) begin
                rsp_valid_r <= 1'b1;                                      // R25
                rsp_byte_r  <= rd_byte;
                rd_idx_r    <= rd_idx_r + 9'h001;
            end else begin
                rsp_valid_r <= 1'b0;
            end
        end
    end

    // trailer is captured when the command ends and shown with done
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            trailer_r  <= '0;
            body_len_r <= CNT_ZERO;
        end else if (do_end) begin
            trailer_r  <= have_sw_r ? first_sw_r : ev_sw;                 // R7 R21
            body_len_r <= count;                                          // R11
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == ST_FIN);
        end
    end

    assign cmd_ready_o = cmd_ready_r;
    assign dat_ready_o = dat_ready_r;
    assign tx_valid_o  = tx_valid_r;
    assign tx_byte_o   = tx_byte_r;
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_byte_o  = rsp_byte_r;
    assign done_o      = done_r;
    assign trailer_o   = trailer_r;
    assign body_len_o  = body_len_r;

    a_resend_keeps_open: assert property ( // R1
        do_resend |=> state_r == ST_HDR && hdr_r.p3 == $past(ev_i.b2))
        else $error("6c pair did not reissue header");

    a_more_not_final: assert property ( // R17
        do_more |=> hdr_r.ins == GR_INS && hdr_r.p3 == $past(ev_i.b2)
                    && hdr_r.cla == GR_CLA)
        else $error("61 pair did not build get response");

    a_end_delivers: assert property ( // R2
        do_end |=> state_r == ST_DLV ##[1:600] done_o)
        else $error("ended command not delivered");

    a_case1_p3_zero: assert property ( // R5
        cmd_take && cmd_i.cmd_case == CASE_1 |=> hdr_r.p3 == P3_ZERO)
        else $error("case 1 p3 not zero");

    a_case2_p3_le: assert property ( // R8
        cmd_take && cmd_i.cmd_case == CASE_2 && !cmd_i.fixed_le
        |=> hdr_r.p3 == $past(cmd_i.le))
        else $error("case 2 p3 not le");

    a_case34_p3_lc: assert property ( // R12
        cmd_take && (cmd_i.cmd_case == CASE_3 || cmd_i.cmd_case == CASE_4)
        |=> hdr_r.p3 == $past(cmd_i.lc))
        else $error("case 3 or 4 p3 not lc");

    a_warn_gr_zero: assert property ( // R18
        do_gr00 |=> hdr_r.ins == GR_INS && hdr_r.p3 == P3_ZERO
                    && state_r == ST_HDR)
        else $error("post data warning did not get response");

    a_first_sw_kept: assert property ( // R21
        do_end && have_sw_r |=> trailer_o == $past(first_sw_r))
        else $error("case 4 trailer not first status");

    a_trailer_copy: assert property ( // R7
        do_end && !have_sw_r && case_r != CASE_4 |=> trailer_o == $past(ev_sw))
        else $error("trailer altered");

    a_zero_le_cap: assert property ( // R24
        cmd_take && le_eff == P3_ZERO |=> cap_r == RSP_MAX)
        else $error("zero le not 256");

    a_header_len: assert property ( // R13
        state_r == ST_HDR && $past(state_r) != ST_HDR
        |-> ##10 state_r == ST_HDR ##[1:30] state_r != ST_HDR)
        else $error("header phase length wrong");

    a_body_count: assert property ( // R25
        rsp_valid_o |-> rd_idx_r <= body_len_o && body_len_o <= cap_r)
        else $error("body overran its length");

endmodule : t0_apdu_transport
`default_nettype wire

// ### t0_apdu_transport_bench.sv
// self-checking bench of the t0 transport engine against a scripted card
`timescale 1ns/100ps
`default_nettype none
module t0_apdu_transport_bench;
    import t0_apdu_pkg::*;
    logic         ref_clk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i = 1'b0;
    logic         dat_valid_i = 1'b0, rsp_ready_i = 1'b0;
    logic [7:0]   dat_byte_i = 8'h00, rsp_byte_o, tx_byte_o;
    apdu_cmd_t    cmd_i = '0;
    logic         cmd_ready_o, dat_ready_o, rsp_valid_o, done_o;
    logic         tx_valid_o, tx_ready_i, ev_valid_i;
    logic [8:0]   body_len_o;
    rsp_trailer_t trailer_o;
    card_ev_t     ev_i;
    integer       seed = 32'h781bd005;
    integer       bad_count = 0, n_checks = 0, cyc = 0, rx_at = 0, k;
    byte unsigned dq[$], sent[$], got[$], exp_body[$];
    logic [15:0]  cont[3] = '{16'h6283, 16'h6300, 16'h9100};
    logic [15:0]  ends[2] = '{16'h6a80, 16'h9000};

    t0_apdu_transport u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
        .dat_valid_i(dat_valid_i), .dat_byte_i(dat_byte_i),
        .dat_ready_o(dat_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_byte_o(rsp_byte_o), .rsp_ready_i(rsp_ready_i), .done_o(done_o),
        .trailer_o(trailer_o), .body_len_o(body_len_o),
        .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
        .tx_ready_i(tx_ready_i), .ev_valid_i(ev_valid_i), .ev_i(ev_i));
    t0_card_model u_card (.ref_clk_i(ref_clk_i), .tx_valid_i(tx_valid_o),
        .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i),
        .ev_valid_o(ev_valid_i), .ev_o(ev_i));

    initial forever #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (dat_valid_i && dat_ready_o) void'(dq.pop_front());
        if (rsp_valid_o && rsp_ready_i) got.push_back(rsp_byte_o);
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end
    always @(negedge ref_clk_i) begin
        dat_valid_i <= (dq.size() > 0);
        dat_byte_i <= (dq.size() > 0) ? dq[0] : 8'($random(seed));
        rsp_ready_i <= 1'($random(seed));
    end

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic start(apdu_cmd_t c);
        int i;
        got = {};
        sent = {};
        exp_body = {};
        if (c.cmd_case inside {CASE_3, CASE_4})
            for (i = 0; i < c.lc; i++) sent.push_back(8'($random(seed)));
        dq = sent;
        @(negedge ref_clk_i);
        cmd_i = c;
        cmd_valid_i = 1'b1;
        do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b0;
    endtask : start
    task automatic hdr(logic [39:0] h);
        int i;
        rx_at += 5;
        wait (u_card.rx.size() >= rx_at);
        for (i = 0; i < 5; i++)
            chk("header byte", h[39-8*i -: 8], u_card.rx[rx_at-5+i]);
    endtask : hdr
    task automatic dat();
        int i;
        rx_at += sent.size();
        wait (u_card.rx.size() >= rx_at);
        for (i = 0; i < sent.size(); i++)
            chk("data byte", sent[i], u_card.rx[rx_at-sent.size()+i]);
    endtask : dat
    // n bytes from the card, only the first keep of them fit the body
    task automatic cdata(int n, int keep);
        int i;
        byte unsigned b;
        for (i = 0; i < n; i++) begin
            b = 8'($random(seed));
            if (i < keep) exp_body.push_back(b);
            u_card.send_ev(EV_DATA, b, 8'h00);
        end
    endtask : cdata
    task automatic fin(logic [15:0] sw);
        int i;
        do @(negedge ref_clk_i); while (done_o !== 1'b1);
        chk("trailer", sw, trailer_o);
        chk("body length", 16'(exp_body.size()), 16'(body_len_o));
        chk("bytes delivered", 16'(exp_body.size()), 16'(got.size()));
        for (i = 0; i < exp_body.size() && i < got.size(); i++)
            chk("body byte", exp_body[i], got[i]);
        chk("card byte count", 16'(rx_at), 16'(u_card.rx.size()));
    endtask : fin
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        nrst_i = 1'b1;
        start('{8'h80, 8'h12, 8'h34, 8'h56, CASE_1, 8'h07, 8'h09, 1'b0});
        hdr(40'h8012345600);
        u_card.send_ev(EV_STATUS, 8'h6a, 8'h82);
        fin(16'h6a82);
        start('{8'h80, 8'hb2, 8'h01, 8'h04, CASE_2, 8'h00, 8'h0a, 1'b0});
        hdr(40'h80b201040a);
        u_card.send_ev(EV_STATUS, SW1_RESEND, 8'h04);
        hdr(40'h80b2010404);
        cdata(4, 4);
        u_card.send_ev(EV_STATUS, SW1_MORE, 8'h03);
        hdr(40'h00c0000003);
        cdata(3, 3);
        u_card.send_ev(EV_STATUS, 8'h90, 8'h00);
        fin(16'h9000);
        start('{8'h00, 8'hb2, 8'h02, 8'h0c, CASE_2, 8'h00, 8'h05, 1'b1});
        hdr(40'h00b2020c00);
        u_card.send_ev(EV_STATUS, 8'h62, 8'h83);
        fin(16'h6283);
        start('{8'h00, 8'hb2, 8'h03, 8'h0c, CASE_2, 8'h00, 8'h02, 1'b0});
        hdr(40'h00b2030c02);
        cdata(3, 2);
        u_card.send_ev(EV_STATUS, 8'h90, 8'h00);
        fin(16'h9000);
        start('{8'h84, 8'h24, 8'h00, 8'h00, CASE_3, 8'h03, 8'h00, 1'b0});
        hdr(40'h8424000003);
        u_card.send_ev(EV_PROC, 8'h24, 8'h00);
        dat();
        u_card.send_ev(EV_STATUS, 8'h63, 8'h00);
        fin(16'h6300);
        start('{8'h84, 8'h24, 8'h00, 8'h01, CASE_3, 8'h02, 8'h00, 1'b0});
        hdr(40'h8424000102);
        u_card.send_ev(EV_STATUS, 8'h69, 8'h85);
        fin(16'h6985);
        for (k = 0; k < 3; k++) begin
            start('{8'h80, 8'hae, 8'h40, 8'h00, CASE_4, 8'h02, 8'h11, 1'b1});
            hdr(40'h80ae400002);
            u_card.send_ev(EV_PROC, 8'hae, 8'h00);
            dat();
            u_card.send_ev(EV_STATUS, cont[k][15:8], cont[k][7:0]);
            hdr(40'h00c0000000);
            cdata(2, 2);
            u_card.send_ev(EV_STATUS, 8'h90, 8'h00);
            fin(cont[k]);
        end
        for (k = 0; k < 2; k++) begin
            start('{8'h80, 8'hae, 8'h80, 8'h00, CASE_4, 8'h01, 8'h00, 1'b0});
            hdr(40'h80ae800001);
            u_card.send_ev(EV_PROC, 8'hae, 8'h00);
            dat();
            u_card.send_ev(EV_STATUS, ends[k][15:8], ends[k][7:0]);
            fin(ends[k]);
        end
        start('{8'h00, 8'ha4, 8'h04, 8'h00, CASE_4, 8'h01, 8'h00, 1'b0});
        hdr(40'h00a4040001);
        u_card.send_ev(EV_PROC, 8'ha4, 8'h00);
        dat();
        u_card.send_ev(EV_STATUS, SW1_MORE, 8'h04);
        hdr(40'h00c0000004);
        u_card.send_ev(EV_STATUS, SW1_RESEND, 8'h02);
        hdr(40'h00c0000002);
        cdata(2, 2);
        u_card.send_ev(EV_STATUS, 8'h90, 8'h00);
        fin(16'h9000);
        wrap_up();
    end
endmodule : t0_apdu_transport_bench
`default_nettype wire

// ### t0_card_model.sv
// behavioural chip card: takes header and data bytes, answers with events
`timescale 1ns/100ps
`default_nettype none
module t0_card_model (
    input  wire logic             ref_clk_i,
    input  wire logic             tx_valid_i,
    input  wire logic [7:0]       tx_byte_i,
    output logic                  tx_ready_o,
    output logic                  ev_valid_o,
    output t0_apdu_pkg::card_ev_t ev_o
);
    import t0_apdu_pkg::*;
    byte unsigned rx[$];
    logic [1:0]   stall_r = 2'h0;
    initial begin
        tx_ready_o = 1'b0;
        ev_valid_o = 1'b0;
        ev_o = '0;
    end
    // refuses one cycle in four so the engine must hold its byte
    always @(negedge ref_clk_i) begin
        stall_r <= stall_r + 2'h1;
        tx_ready_o <= (stall_r != 2'h0);
    end
    always @(posedge ref_clk_i) begin
        if (tx_valid_i && tx_ready_o) rx.push_back(tx_byte_i);
    end
    // the bench scripts replies for the latest header only
    task automatic send_ev(card_ev_kind_t k, logic [7:0] a, logic [7:0] b);
        repeat (3) @(negedge ref_clk_i);
        ev_valid_o = 1'b1;
        ev_o = {k, a, b};
        @(negedge ref_clk_i);
        ev_valid_o = 1'b0;
        // idle lines must not keep showing the last event
        ev_o = ~ev_o;
    endtask : send_ev
endmodule : t0_card_model
`default_nettype wire
